// ---- logic/led_dimming_output_generator.sv ----
// LED string dimming generator: AHB-Lite registers, method selection and current level
//
// Implementation choices: the AHB-Lite slave port and the address map.
`timescale 1ns/1ns
`include "dim_map.svh"
module led_dimming_output_generator
#(
  parameter int unsigned CLK_HZ = `DIM_CLK_HZ
)
(
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          hsel,
  input  wire dim_pkg::word_t haddr,
  input  wire logic [1:0]    htrans,
  input  wire logic          hwrite,
  input  wire logic [2:0]    hsize,
  input  wire dim_pkg::word_t hwdata,
  input  wire logic          hready,
  output dim_pkg::word_t     hrdata,
  output logic               hreadyout,
  output logic               hresp,
  input  wire logic          pwm_in,
  input  wire logic          rate_set_pin,
  input  wire logic [15:0]   in_duty,
  output logic [5:0]         string_pwm,
  output logic [11:0]        current_code,
  output logic [2:0]         full_scale_sel,
  output logic               ext_level_ref,
  output logic               boost_1250k,
  output logic               active
);
  import dim_pkg::*;

  localparam rate_tbl_t  rate_hz  = `DIM_RATE_HZ;
  localparam rate_tbl_t  rate_res = `DIM_RATE_RES;
  localparam range_tbl_t range_ma = `DIM_RANGE_MA;

  // Divider per rate computed at elaboration so no runtime divide is built
  function automatic rate_tbl_t make_ticks();
    rate_tbl_t t;
    for (int j = 0; j < 16; j++)
    begin
      t[j] = CLK_HZ / (rate_hz[j] << rate_res[j]);
      if (t[j] == 0)
        t[j] = 1;
    end
    return t;
  endfunction

  localparam rate_tbl_t tick_tbl = make_ticks();

  // One-hot register select shared by the read and write paths
  function automatic logic [6:0] reg_sel(input logic [7:0] a);
    logic [6:0] r;
    r = 7'h0;
    case (a)
      `DIM_OFF_CTRL:   r = 7'h01;
      `DIM_OFF_CFG:    r = 7'h02;
      `DIM_OFF_BRT:    r = 7'h04;
      `DIM_OFF_LEVEL:  r = 7'h08;
      `DIM_OFF_SWITCH: r = 7'h10;
      `DIM_OFF_STATUS: r = 7'h20;
      `DIM_OFF_MEAS:   r = 7'h40;
      default:         r = 7'h00;
    endcase
    return r;
  endfunction

  function automatic dim_method_t method_of(input logic [1:0] m);
    dim_method_t d;
    case (m)
      2'b00:   d = DIM_PWM;
      2'b01:   d = DIM_CURRENT;
      2'b10:   d = DIM_HYBRID;
      default: d = DIM_PWM;
    endcase
    return d;
  endfunction

  // Codes 0..4 drive 1..5 strings, 5..7 all six
  function automatic logic [5:0] phase_mask(input logic [2:0] c);
    logic [2:0] n;
    n = (c >= 3'(`DIM_STRINGS - 1)) ? 3'(`DIM_STRINGS) : c + 3'h1;
    return 6'h3f >> (3'(`DIM_STRINGS) - n);
  endfunction

  dim_state_t  s;
  dim_state_t  next_s;
  dim_drive_if drv ();

  logic [6:0]  wsel;
  logic [6:0]  rsel;
  logic [23:0] mixed;
  logic [27:0] lvl_b;
  logic [27:0] lvl_sw;
  logic [16:0] frac;
  logic [11:0] level_now;
  logic [16:0] div_try;
  logic        follow;
  logic [3:0]  code;
  logic [4:0]  res;
  logic [40:0] follow_duty;
  logic [1:0]  src;
  logic [7:0]  ma;

  always_comb
  begin
    next_s      = s;
    wsel        = reg_sel(s.wr_addr);
    rsel        = reg_sel(haddr[7:0]);
    src         = s.ctrl[`DIM_CTRL_SRC_LSB +: 2];
    mixed       = in_duty * s.brt;
    lvl_b       = s.level * s.bright;
    lvl_sw      = s.level * s.swpt;
    frac        = {1'b0, s.bright};
    level_now   = s.level;
    div_try     = {s.div_rem[15:0], 1'b0};
    ma          = 8'(range_ma[s.act_range]);
    // Resistor rate path: grounded pin follows input, otherwise fixed 9616 Hz
    follow      = s.act_rrate & ~s.rate_set_pin_s2;
    code        = s.act_rrate ? `DIM_PIN_HIGH_RATE : s.act_rate;
    res         = 5'(rate_res[code]);
    follow_duty = s.in_period * frac;

    // Pin synchronisers; edge detect looks only at the second stage
    next_s.pin_s1  = pwm_in;
    next_s.pin_s2  = s.pin_s1;
    next_s.pin_d   = s.pin_s2;
    next_s.rate_set_pin_s1 = rate_set_pin;
    next_s.rate_set_pin_s2 = s.rate_set_pin_s1;
    next_s.in_edge = s.pin_s2 & ~s.pin_d;
    if (next_s.in_edge)
    begin
      next_s.in_period = s.in_cnt + 24'h1;
      next_s.in_cnt    = 24'h0;
    end
    else if (s.in_cnt != 24'hffffff)
    begin
      next_s.in_cnt = s.in_cnt + 24'h1;
    end

    // Bus slave: zero wait states, writes land in the data phase
    next_s.hreadyout = 1'b1;
    next_s.hresp     = 1'b0;
    next_s.wr_pend   = 1'b0;
    if (s.wr_pend)
    begin
      if (wsel[0])
        next_s.ctrl = hwdata & `DIM_CTRL_MASK;
      if (wsel[1])
        next_s.cfg = hwdata & `DIM_CFG_MASK;
      if (wsel[2])
        next_s.brt = hwdata[7:0];
      if (wsel[3])
        next_s.level = hwdata[11:0];
      if (wsel[4])
        next_s.swpt = hwdata[15:0];
    end
    if (hsel && hready && htrans[1])
    begin
      if (hwrite)
      begin
        next_s.wr_pend = 1'b1;
        next_s.wr_addr = haddr[7:0];
      end
      else
      begin
        next_s.hrdata = 32'h0;
        if (rsel[0])
          next_s.hrdata = s.ctrl;
        if (rsel[1])
          next_s.hrdata = s.cfg;
        if (rsel[2])
          next_s.hrdata = {24'h0, s.brt};
        if (rsel[3])
          next_s.hrdata = {20'h0, s.level};
        if (rsel[4])
          next_s.hrdata = {16'h0, s.swpt};
        if (rsel[5])
        begin
          next_s.hrdata[`DIM_ST_CODE_LSB +: 12] = s.current_code;
          next_s.hrdata[`DIM_ST_PWM_LSB +: 6]   = s.string_pwm;
          next_s.hrdata[`DIM_ST_ACTIVE_BIT]     = s.active;
          next_s.hrdata[`DIM_ST_PINHI_BIT]      = s.rate_set_pin_s2;
          next_s.hrdata[`DIM_ST_MA_LSB +: 8]    = ma;
        end
        if (rsel[6])
          next_s.hrdata = {16'h0, s.bright};
      end
    end

    // Enable sequencing; configuration is frozen while running
    case (s.st)
      RUN_IDLE:
      begin
        if (s.ctrl[`DIM_CTRL_EN_BIT])
        begin
          next_s.st         = RUN_ACTIVE;
          next_s.act_method = method_of(s.ctrl[`DIM_CTRL_METH_LSB +: 2]);
          next_s.act_rate   = s.cfg[`DIM_CFG_RATE_LSB +: 4];
          next_s.act_rrate  = s.cfg[`DIM_CFG_RRATE_BIT];
          next_s.act_rlevel = s.cfg[`DIM_CFG_RLEVEL_BIT];
          next_s.act_range  = s.cfg[`DIM_CFG_RANGE_LSB +: 3];
          next_s.act_phase  = s.cfg[`DIM_CFG_PHASE_LSB +: 3];
          next_s.act_stag   = s.cfg[`DIM_CFG_STAG_BIT];
        end
      end
      RUN_ACTIVE:
      begin
        if (!s.ctrl[`DIM_CTRL_EN_BIT])
          next_s.st = RUN_IDLE;
      end
      default:
      begin
        next_s.st = RUN_IDLE;
      end
    endcase

    // Brightness source; no curve shaper here, so 01 and 11 coincide
    case (src)
      2'b00:   next_s.bright = in_duty;
      2'b10:   next_s.bright = {s.brt, s.brt};
      default: next_s.bright = mixed[23:8];
    endcase

    // Serial divider gives bright / switch point for the PWM part of hybrid
    if (s.div_cnt == 5'h0)
    begin
      next_s.div_cnt = `DIM_DIV_STEPS;
      next_s.div_rem = {1'b0, s.bright};
      next_s.div_den = (s.swpt == 16'h0) ? 16'h1 : s.swpt;
      next_s.div_q   = 16'h0;
    end
    else
    begin
      next_s.div_cnt = s.div_cnt - 5'h1;
      if (div_try >= {1'b0, s.div_den})
      begin
        next_s.div_rem = div_try - {1'b0, s.div_den};
        next_s.div_q   = {s.div_q[14:0], 1'b1};
      end
      else
      begin
        next_s.div_rem = div_try;
        next_s.div_q   = {s.div_q[14:0], 1'b0};
      end
      if (s.div_cnt == 5'h1)
        next_s.quot = next_s.div_q;
    end

    case (s.act_method)
      DIM_PWM:
      begin
        frac      = {1'b0, s.bright};
        level_now = s.level;
      end
      DIM_CURRENT:
      begin
        frac      = `DIM_FRAC_FULL;
        level_now = lvl_b[27:16];
      end
      DIM_HYBRID:
      begin
        if (s.bright >= s.swpt)
        begin
          frac      = `DIM_FRAC_FULL;
          level_now = lvl_b[27:16];
        end
        else
        begin
          frac      = {1'b0, s.quot};
          level_now = lvl_sw[27:16];
        end
      end
      default:
      begin
        frac      = {1'b0, s.bright};
        level_now = s.level;
      end
    endcase
    follow_duty = s.in_period * frac;

    // Registered outputs
    next_s.active         = (s.st == RUN_ACTIVE);
    next_s.full_scale_sel = s.act_range;
    next_s.ext_level_ref  = s.act_rlevel;
    next_s.boost_1250k    = s.act_rrate;
    if (s.st != RUN_ACTIVE)
    begin
      next_s.string_pwm   = 6'h0;
      next_s.current_code = 12'h0;
    end
    else if (s.ctrl[`DIM_CTRL_PASS_BIT])
    begin
      next_s.string_pwm   = {6{s.pin_s2}} & phase_mask(s.act_phase);
      next_s.current_code = s.level;
    end
    else
    begin
      next_s.string_pwm   = drv.pwm;
      next_s.current_code = level_now;
    end
  end

  // Timebase parameters for the string generator
  assign drv.run        = (s.st == RUN_ACTIVE);
  assign drv.period_len = follow ? s.in_period : 24'h1 << res;
  assign drv.duty_len   = follow ? follow_duty[39:16] : 24'(frac >> (5'd16 - res));
  assign drv.tick_div   = follow ? 16'h1 : 16'(tick_tbl[code]);
  assign drv.restart    = follow & s.in_edge;
  assign drv.staggered  = s.act_stag;
  assign drv.string_en  = phase_mask(s.act_phase);

  string_phase_gen u_gen
  (
    .clk (clk),
    .rst (rst),
    .drv (drv.gen)
  );

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s           <= '0;
      s.hreadyout <= 1'b1;
      s.ctrl      <= `DIM_CTRL_RST;
      s.cfg       <= `DIM_CFG_RST;
      s.brt       <= `DIM_BRT_RST;
      s.level     <= `DIM_LEVEL_RST;
      s.swpt      <= `DIM_SWITCH_RST;
      s.st        <= RUN_IDLE;
      s.act_method <= DIM_PWM;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign hrdata         = s.hrdata;
  assign hreadyout      = s.hreadyout;
  assign hresp          = s.hresp;
  assign string_pwm     = s.string_pwm;
  assign current_code   = s.current_code;
  assign full_scale_sel = s.full_scale_sel;
  assign ext_level_ref  = s.ext_level_ref;
  assign boost_1250k    = s.boost_1250k;
  assign active         = s.active;
endmodule

// ---- logic/dim_map.svh ----
// Register map, field positions, reset values and timing tables of the dimming generator
`ifndef DIM_MAP_SVH
`define DIM_MAP_SVH

`define DIM_CLK_HZ          10000000

`define DIM_OFF_CTRL        8'h00
`define DIM_OFF_CFG         8'h04
`define DIM_OFF_BRT         8'h08
`define DIM_OFF_LEVEL       8'h0c
`define DIM_OFF_SWITCH      8'h10
`define DIM_OFF_STATUS      8'h14
`define DIM_OFF_MEAS        8'h18

`define DIM_CTRL_EN_BIT     0
`define DIM_CTRL_PASS_BIT   1
`define DIM_CTRL_SRC_LSB    2
`define DIM_CTRL_METH_LSB   4
`define DIM_CTRL_MASK       32'h0000003f

`define DIM_CFG_RATE_LSB    0
`define DIM_CFG_RRATE_BIT   4
`define DIM_CFG_RLEVEL_BIT  5
`define DIM_CFG_RANGE_LSB   6
`define DIM_CFG_PHASE_LSB   9
`define DIM_CFG_STAG_BIT    12
`define DIM_CFG_MASK        32'h00001fff

`define DIM_ST_CODE_LSB     0
`define DIM_ST_PWM_LSB      12
`define DIM_ST_ACTIVE_BIT   18
`define DIM_ST_PINHI_BIT    19
`define DIM_ST_MA_LSB       20

`define DIM_CTRL_RST        32'h00000000
`define DIM_CFG_RST         32'h00001e04
`define DIM_BRT_RST         8'hff
`define DIM_LEVEL_RST       12'hfff
`define DIM_SWITCH_RST      16'h8000

`define DIM_RATE_HZ  '{4808, 6010, 7212, 8414, 9616, 12020, 13222, 14424, \
  15626, 16828, 18030, 19232, 24040, 28848, 33656, 38464}
`define DIM_RATE_RES '{11, 10, 10, 10, 10, 9, 9, 9, 9, 9, 9, 9, 8, 8, 8, 8}
`define DIM_RANGE_MA '{5, 10, 15, 20, 23, 25, 30, 50}
`define DIM_PIN_HIGH_RATE   4'h4
`define DIM_BRT_W           16
`define DIM_PER_W           24
`define DIM_STRINGS         6
`define DIM_FRAC_FULL       17'h10000
`define DIM_DIV_STEPS       5'h10

`endif

// ---- logic/dim_pkg.sv ----
// Types shared by the dimming generator modules
package dim_pkg;

  typedef logic [31:0] word_t;
  typedef int unsigned rate_tbl_t [16];
  typedef int unsigned range_tbl_t [8];

  typedef enum logic [2:0]
  {
    DIM_PWM     = 3'b001,
    DIM_CURRENT = 3'b010,
    DIM_HYBRID  = 3'b100
  } dim_method_t;

  typedef enum logic [1:0]
  {
    RUN_IDLE   = 2'b01,
    RUN_ACTIVE = 2'b10
  } run_state_t;

  typedef struct packed
  {
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        wr_pend;
    logic [7:0]  wr_addr;
    logic [31:0] ctrl;
    logic [31:0] cfg;
    logic [7:0]  brt;
    logic [11:0] level;
    logic [15:0] swpt;
    run_state_t  st;
    dim_method_t act_method;
    logic [3:0]  act_rate;
    logic        act_rrate;
    logic        act_rlevel;
    logic [2:0]  act_range;
    logic [2:0]  act_phase;
    logic        act_stag;
    logic        pin_s1;
    logic        pin_s2;
    logic        pin_d;
    logic        rate_set_pin_s1;
    logic        rate_set_pin_s2;
    logic [23:0] in_cnt;
    logic [23:0] in_period;
    logic        in_edge;
    logic [15:0] bright;
    logic [4:0]  div_cnt;
    logic [16:0] div_rem;
    logic [15:0] div_q;
    logic [15:0] div_den;
    logic [15:0] quot;
    logic [5:0]  string_pwm;
    logic [11:0] current_code;
    logic [2:0]  full_scale_sel;
    logic        ext_level_ref;
    logic        boost_1250k;
    logic        active;
  } dim_state_t;

  typedef struct packed
  {
    logic [15:0] tick;
    logic [23:0] cnt;
    logic [5:0]  pwm;
  } gen_state_t;

endpackage

// ---- logic/dim_drive_if.sv ----
// Drive parameters passed from the dimming core to the string timebase
`timescale 1ns/1ns
interface dim_drive_if;
  logic        run;
  logic [23:0] period_len;
  logic [23:0] duty_len;
  logic [15:0] tick_div;
  logic        restart;
  logic        staggered;
  logic [5:0]  string_en;
  logic [5:0]  pwm;

  modport ctrl (output run, period_len, duty_len, tick_div, restart, staggered, string_en,
                input pwm);
  modport gen  (input run, period_len, duty_len, tick_div, restart, staggered, string_en,
                output pwm);
endinterface

// ---- logic/string_phase_gen.sv ----
// Output PWM timebase with per-string phase offsets
`timescale 1ns/1ns
`include "dim_map.svh"
module string_phase_gen
(
  input wire logic clk,
  input wire logic rst,
  dim_drive_if.gen drv
);
  import dim_pkg::*;

  gen_state_t  s;
  gen_state_t  next_s;
  logic [23:0] pos [`DIM_STRINGS];

  genvar i;
  generate
    for (i = 0; i < `DIM_STRINGS; i++)
    begin : g_str
      logic [26:0] prod;
      logic [23:0] off;
      // Six equal slots per period whatever the string count, so only enabled strings pulse and the other slots stay empty
      assign prod = drv.period_len * 3'(i);
      assign off  = 24'(prod / 27'd6);
      assign pos[i] = !drv.staggered ? s.cnt :
                      (s.cnt >= off) ? s.cnt - off : 24'(s.cnt + drv.period_len - off);
    end
  endgenerate

  always_comb
  begin
    next_s = s;
    // Own timebase; input edges only restart it in follow mode
    if (!drv.run || drv.restart)
    begin
      next_s.tick = 16'h0;
      next_s.cnt  = 24'h0;
    end
    else if (s.tick + 16'h1 >= drv.tick_div)
    begin
      next_s.tick = 16'h0;
      next_s.cnt  = (s.cnt + 24'h1 >= drv.period_len) ? 24'h0 : s.cnt + 24'h1;
    end
    else
    begin
      next_s.tick = s.tick + 16'h1;
    end
    for (int k = 0; k < `DIM_STRINGS; k++)
    begin
      next_s.pwm[k] = drv.run & drv.string_en[k] & (pos[k] < drv.duty_len);
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      s <= '0;
    else
      s <= next_s;
  end

  assign drv.pwm = s.pwm;
endmodule

// ---- testbench/pwm_source.sv ----
// Host-side input PWM source together with its measured duty word
`timescale 1ns/1ns
module pwm_source
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [15:0] period_cyc,
  input  wire logic [15:0] high_cyc,
  output logic             pwm_in,
  output logic [15:0]      in_duty
);
  logic [15:0] cnt;
  // Duty is the high time as a 16-bit fraction of the period, as a detector reports it
  always_ff @(posedge clk)
  begin
    if (rst || cnt >= period_cyc - 16'h1)
      cnt <= 16'h0;
    else
      cnt <= cnt + 16'h1;
    pwm_in <= !rst && cnt < high_cyc;
    in_duty <= 16'((32'(high_cyc) << 16) / 32'(period_cyc));
  end
endmodule

// ---- testbench/led_dimming_props.sv ----
// Concurrent checks on the ports of the LED dimming generator
`timescale 1ns/1ns
module led_dimming_props
(
  input wire logic           clk,
  input wire logic           rst,
  input wire logic           hsel,
  input wire dim_pkg::word_t haddr,
  input wire logic [1:0]     htrans,
  input wire logic           hwrite,
  input wire dim_pkg::word_t hwdata,
  input wire logic           hready,
  input wire logic [5:0]     string_pwm,
  input wire logic [11:0]    current_code,
  input wire logic [2:0]     full_scale_sel,
  input wire logic           ext_level_ref,
  input wire logic           boost_1250k,
  input wire logic           active
);
  import dim_pkg::*;
  logic [7:0] ph_addr;
  logic       ph_valid;
  logic       ph_write;
  logic       act_q;
  word_t      cfg_sh;
  word_t      ctrl_sh;
  word_t      cfg_cap;
  logic [5:0] str_mask;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Shadows of what software wrote, so captured outputs can be judged against them
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ph_valid <= 1'b0;
      cfg_sh <= 32'h00001e04;
      ctrl_sh <= 32'h0;
    end
    else
    begin
      if (ph_valid && ph_write && ph_addr == 8'h04)
        cfg_sh <= hwdata;
      if (ph_valid && ph_write && ph_addr == 8'h00)
        ctrl_sh <= hwdata;
      ph_valid <= hsel && hready && htrans[1];
    end
    ph_addr <= haddr[7:0];
    ph_write <= hwrite;
    act_q <= active;
    if (active && !act_q)
      cfg_cap <= cfg_sh;
  end
  always_comb
    str_mask = (cfg_cap[11:9] > 3'h4) ? 6'h3f : 6'(6'h3f >> (3'h5 - cfg_cap[11:9]));
  sequence ctrl_wr;
    ph_valid && ph_write && ph_addr == 8'h00;
  endsequence
  sequence ctrl_on;
    ctrl_wr ##0 hwdata[0];
  endsequence
  sequence ctrl_off;
    ctrl_wr ##0 !hwdata[0];
  endsequence
  a_enable_start: assert property (ctrl_on |-> ##[1:3] active)
    else $error("enable write did not start the outputs");
  a_disable_stop: assert property (ctrl_off |-> ##[1:3] !active)
    else $error("disable write did not stop the outputs");
  a_idle_no_current: assert property (!active && !$past(active)
    |-> current_code == 12'h000)
    else $error("level code not zero while idle");
  a_held_config: assert property (active && $past(active, 2) |-> $stable(full_scale_sel)
    && $stable(ext_level_ref) && $stable(boost_1250k))
    else $error("captured configuration moved while active");
  a_range_capture: assert property ($rose(active) |-> ##[0:1]
    (full_scale_sel == cfg_sh[8:6] && ext_level_ref == cfg_sh[5]))
    else $error("range or reference not captured at enable");
  a_boost_capture: assert property ($rose(active) |-> ##[0:1]
    boost_1250k == cfg_sh[4])
    else $error("boost rate flag not captured at enable");
  a_string_mask: assert property (active && $past(active, 3)
    |-> (string_pwm & ~str_mask) == 6'h00)
    else $error("disabled string driven");
  a_stagger_spread: assert property (active && $past(active, 3) && cfg_cap[12]
    && !cfg_cap[4] && !ctrl_sh[1] |-> $countones(string_pwm & ~$past(string_pwm)) <= 1)
    else $error("staggered strings switched on together");
endmodule

bind led_dimming_output_generator led_dimming_props u_props
(
  .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hwdata(hwdata), .hready(hready), .string_pwm(string_pwm), .current_code(current_code),
  .full_scale_sel(full_scale_sel), .ext_level_ref(ext_level_ref), .boost_1250k(boost_1250k),
  .active(active)
);

// ---- testbench/tb_led_dimming_output_generator.sv ----
// Self-checking testbench of the LED dimming generator
`timescale 1ns/1ns
`include "dim_map.svh"
module tb_led_dimming_output_generator;
  import dim_pkg::*;
  localparam rate_tbl_t RES = `DIM_RATE_RES;
  localparam range_tbl_t MA = `DIM_RANGE_MA;
  logic        clk = 0, rst = 1, hsel = 0, hwrite = 0, pin = 1;
  logic [1:0]  htrans = 0;
  logic [2:0]  hsize = 3'h2, full_scale_sel;
  word_t       haddr = 0, hwdata = 0, hrdata, rd;
  logic        hreadyout, hresp, pwm_in, ext_level_ref, boost_1250k, active;
  logic [15:0] in_duty;
  logic [5:0]  string_pwm;
  logic [11:0] current_code;
  int          failures = 0, total_checks = 0, cycles = 0, hi, rises, mx;

  led_dimming_output_generator dut_u
  (
    .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .pwm_in(pwm_in), .rate_set_pin(pin),
    .in_duty(in_duty), .string_pwm(string_pwm), .current_code(current_code),
    .full_scale_sel(full_scale_sel), .ext_level_ref(ext_level_ref),
    .boost_1250k(boost_1250k), .active(active)
  );
  // Input period of 600 cycles is unrelated to every fixed-rate output period on purpose
  pwm_source src_u
  (
    .clk(clk), .rst(rst), .period_cyc(16'h0258), .high_cyc(16'h0096),
    .pwm_in(pwm_in), .in_duty(in_duty)
  );

  always #50 clk = ~clk;

  task automatic final_report;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      failures++;
      $display("ERROR %0t timeout", $time);
      final_report();
    end
  end

  task automatic chk(input word_t got, input word_t exp, input string m);
    total_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input word_t d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  // Restart from idle so the configuration is captured afresh
  task automatic run(input word_t ctrl, input word_t cfg, input logic [7:0] b);
    bus(1, `DIM_OFF_CTRL, 32'h0);
    bus(1, `DIM_OFF_CFG, cfg);
    bus(1, `DIM_OFF_BRT, {24'h0, b});
    bus(1, `DIM_OFF_CTRL, ctrl | 32'h1);
    repeat (40) @(posedge clk);
    chk(active, 1, "active");
  endtask

  task automatic meas(input int n, input int i);
    logic [5:0] prev;
    int e;
    hi = 0;
    rises = 0;
    mx = 0;
    @(negedge clk);
    prev = string_pwm;
    repeat (n)
    begin
      @(negedge clk);
      e = $countones(string_pwm & ~prev);
      hi += string_pwm[i];
      rises += e;
      mx = (e > mx) ? e : mx;
      prev = string_pwm;
    end
  endtask

  task automatic t_regs;
    logic [7:0] a[6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h1c};
    word_t e[6] = '{32'h0, 32'h1e04, 32'hff, 32'hfff, 32'h8000, 32'h0};
    for (int k = 0; k < 6; k++)
    begin
      bus(0, a[k], 32'h0);
      chk(rd, e[k], "reset value");
      chk({hreadyout, hresp}, 32'h2, "bus response");
    end
  endtask

  task automatic t_rates;
    for (int c = 0; c < 16; c++)
    begin
      run(32'h9, word_t'(c), 8'h40);
      meas(1 << RES[c], 0);
      chk(hi, 32'h4040 >> (16 - RES[c]), "duty");
      chk(rises, 1, "one pulse");
      chk(current_code, 32'hfff, "fixed level");
    end
  endtask

  task automatic t_level;
    logic [7:0] b;
    for (int r = 0; r < 8; r++)
    begin
      b = 8'h1f + 8'(r * 32);
      run(32'h19, word_t'(r << 6 | (r & 1) << 5), b);
      chk(current_code, (32'hfff * {b, b}) >> 16, "level");
      chk(full_scale_sel, r, "range");
      chk(ext_level_ref, r & 1, "reference");
      bus(0, `DIM_OFF_STATUS, 32'h0);
      chk(rd[27:20], MA[r], "full scale");
    end
    bus(1, `DIM_OFF_CFG, 32'h0);
    chk(full_scale_sel, 7, "held range");
    meas(2048, 0);
    chk(hi, 2048, "full duty");
  endtask

  task automatic t_hybrid;
    run(32'h29, 32'h0, 8'hc0);
    chk(current_code, (32'hfff * 32'hc0c0) >> 16, "upper level");
    run(32'h29, 32'h0, 8'h20);
    chk(current_code, 32'h7ff, "switch level");
    meas(2048, 0);
    chk(hi >= 510 && hi <= 518, 1, "lower duty");
    bus(1, `DIM_OFF_SWITCH, 32'h0);
    run(32'h29, 32'h0, 8'h20);
    chk(current_code, (32'hfff * 32'h2020) >> 16, "zero switch");
    run(32'h39, 32'h0, 8'hc0);
    chk(current_code, 32'hfff, "method code three as pwm");
  endtask

  task automatic t_phase;
    run(32'h9, 32'h1a0f, 8'h40);
    meas(256, 0);
    chk(hi, 64, "staggered duty");
    chk(rises, 6, "six pulses");
    chk(mx, 1, "spread");
    run(32'h9, 32'h0a0f, 8'h40);
    meas(256, 0);
    chk(mx, 6, "aligned");
    run(32'h9, 32'h140f, 8'h40);
    meas(256, 0);
    chk(rises, 3, "three strings");
  endtask

  task automatic t_pass;
    run(32'h3, 32'h020f, 8'h00);
    meas(1200, 1);
    chk(hi, 300, "copy duty");
    chk(rises, 4, "copy edges");
  endtask

  task automatic t_pin;
    run(32'h9, 32'h10, 8'h40);
    chk(boost_1250k, 1, "boost high pin");
    meas(1024, 0);
    chk(hi, 257, "pin high duty");
    @(posedge clk);
    pin <= 1'b0;
    run(32'h9, 32'h10, 8'h01);
    chk(boost_1250k, 1, "boost low pin");
    meas(2400, 0);
    chk(rises, 4, "follows input");
  endtask

  task automatic t_source;
    word_t e[4] = '{32'h4000, 32'h2000, 32'h8080, 32'h2000};
    for (int s = 0; s < 4; s++)
    begin
      run(word_t'(s << 2), 32'h0, 8'h80);
      bus(0, `DIM_OFF_MEAS, 32'h0);
      chk(rd, e[s], "source");
    end
  endtask

  initial
  begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_rates();
    t_level();
    t_hybrid();
    t_phase();
    t_pass();
    t_source();
    t_pin();
    final_report();
  end
endmodule
